// File: core/drs_pkg.sv
/*
 drs_pkg: constants, register map, field layouts and state codes for the
 drive restart and start control block.
 Assumes a 20 MHz system clock and a 1 ms internal tick.
*/
package drs_pkg;
	// timing
	localparam int CLK_HZ = 20_000_000;
	localparam int TICK_HZ = 1000;
	localparam int TICK_CYC = CLK_HZ / TICK_HZ;
	localparam int FAN_HOLD_MIN = 10;
	localparam int FAN_HOLD_TICKS = FAN_HOLD_MIN * 60 * TICK_HZ;
	localparam int SEARCH_MAX_DS = 12;
	localparam int SEARCH_MAX_TICKS = SEARCH_MAX_DS * TICK_HZ / 10;
	localparam int SDLY_UNIT_TICKS = TICK_HZ / 10;
	localparam logic [6:0] SDLY_MAX = 7'h64;

	// register byte addresses
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_RINT = 8'h04;
	localparam logic [7:0] A_SDLY = 8'h08;
	localparam logic [7:0] A_OASG = 8'h0c;
	localparam logic [7:0] A_IASG = 8'h10;
	localparam logic [7:0] A_CMD = 8'h14;
	localparam logic [7:0] A_STAT = 8'h18;
	localparam logic [7:0] A_FREF = 8'h1c;
	localparam logic [7:0] A_FLIM = 8'h20;
	localparam logic [7:0] A_STEP = 8'h24;

	// reset values, control write mask and command bit
	localparam logic [31:0] CTRL_MASK = 32'h0000_0fff;
	localparam logic [15:0] RINT_RST = 16'h03e8;
	localparam logic [6:0] SDLY_RST = 7'h00;
	localparam logic [15:0] FREF_RST = 16'h0000;
	localparam logic [15:0] MAXF_RST = 16'h1770;
	localparam logic [15:0] BASEF_RST = 16'h1770;
	localparam logic [15:0] STEP_RST = 16'h000a;
	localparam int CMD_ALM_CLR = 0;

	// terminal function codes
	localparam int ASG_W = 6;
	localparam logic [5:0] FUNC_RETRY = 6'h1a;
	localparam logic [5:0] FUNC_SEARCH = 6'h1a;

	// ramp zones in percent of maximum frequency
	localparam logic [6:0] ZONE_WEAK = 7'h05;
	localparam logic [6:0] ZONE_STRONG = 7'h0a;
	localparam logic [6:0] PCT_FULL = 7'h64;

	// selections
	localparam logic [1:0] DIR_REV_BLK = 2'h1;
	localparam logic [1:0] DIR_FWD_BLK = 2'h2;
	localparam logic [1:0] SM_OFF = 2'h0;
	localparam logic [1:0] SM_PF = 2'h1;
	localparam logic [1:0] SM_BOTH = 2'h2;

	typedef enum logic [1:0] {
		SH_LIN = 2'h0,
		SH_WEAK = 2'h1,
		SH_STRONG = 2'h2,
		SH_CURV = 2'h3
	} drs_shape_t;

	typedef struct packed {
		logic [19:0] rsvd;
		logic pfr;
		logic [1:0] smode;
		logic [1:0] dir;
		drs_shape_t shape;
		logic fan;
		logic [3:0] lim;
	} drs_ctrl_t;

	typedef struct packed {
		logic [15:0] est;
		logic found;
		logic pf;
		logic temp_low;
		logic [6:0] cause;
		logic trip;
		logic [4:0] din;
		logic coast;
		logic rev;
		logic fwd;
	} drs_pins_t;

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_DELAY = 6'h02,
		ST_SEARCH = 6'h04,
		ST_RUN = 6'h08,
		ST_TRIP = 6'h10,
		ST_ALARM = 6'h20
	} drs_state_t;
endpackage

// File: core/drs_ramp_if.sv
/*
 drs_ramp_if: carries ramp commands from the sequencer to the ramp
 generator and the output frequency back.
 Assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface drs_ramp_if;
	import drs_pkg::*;
	logic tick;
	logic load;
	logic [15:0] load_val;
	logic [15:0] target;
	logic [15:0] maxf;
	logic [15:0] basef;
	logic [15:0] step;
	drs_shape_t shape;
	logic [15:0] freq;
	logic at_target;
	modport ctl(output tick, load, load_val, target, maxf, basef, step,
		shape, input freq, at_target);
	modport ramp(input tick, load, load_val, target, maxf, basef, step,
		shape, output freq, at_target);
endinterface

// File: core/drs_ramp.sv
/*
 drs_ramp: output frequency ramp generator, one step per tick.
 Assumes a synchronised active-low reset and a one-cycle tick pulse.
*/
`timescale 1ns/1ps
module drs_ramp import drs_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// sequencer side
	drs_ramp_if.ramp rif
);
	logic [15:0] freq;
	logic [15:0] start;
	logic [15:0] tgt_q;
	logic [15:0] zone;
	logic [15:0] rate;
	logic [15:0] d_start;
	logic [15:0] d_end;
	logic [15:0] next_freq;
	logic [6:0] pct;
	logic [22:0] zone_prod;

	always_comb begin
		pct = (rif.shape == SH_STRONG) ? ZONE_STRONG : ZONE_WEAK;
		zone_prod = {7'h00, rif.maxf} * {16'h0000, pct};
		zone = 16'(zone_prod / {16'h0000, PCT_FULL});
		d_start = (freq >= start) ? freq - start : start - freq;
		d_end = (rif.target >= freq) ? rif.target - freq : freq - rif.target;
		rate = rif.step;
		// half rate in the rounded zones stretches the ramp
		if ((rif.shape == SH_WEAK || rif.shape == SH_STRONG) &&
			(d_start < zone || d_end < zone)) begin
			rate = rif.step >> 1;
		end
		if (rif.shape == SH_CURV && freq > rif.basef) begin
			rate = rif.step >> 1;
		end
		// a step of one cannot be halved; it stays linear
		if (rate == 16'h0000) begin
			rate = rif.step;
		end
		if (d_end <= rate) begin
			next_freq = rif.target;
		end else if (freq < rif.target) begin
			next_freq = freq + rate;
		end else begin
			next_freq = freq - rate;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			freq <= 16'h0000;
			start <= 16'h0000;
			tgt_q <= 16'h0000;
		end else begin
			tgt_q <= rif.target;
			if (rif.load) begin
				freq <= rif.load_val;
				start <= rif.load_val;
			end else begin
				if (rif.tick) begin
					freq <= next_freq;
				end
				if (rif.target != tgt_q) begin
					start <= freq;
				end
			end
		end
	end

	assign rif.freq = freq;
	assign rif.at_target = (freq == rif.target);
endmodule

// File: core/drs_top.sv
/*
 drs_top: run-control sequencer of a motor drive: automatic retry after
 resettable trips, final alarm, cooling fan control, direction
 inhibition, idling speed search at start, and ramp shape selection.
 Assumes an APB master on CLOCK; all terminal inputs are asynchronous.
*/
// Behaviour
// - resettable trip retries without alarm
// - trips beyond limit raise alarm, stop retrying
// - only seven trip causes are retried
// - limit zero disables retry entirely
// - wait retry interval before each reset
// - retry flag selectable on outputs, code 26
// - fan select: 1 temperature controlled, 0 always
// - fan runs at least ten minutes once on
// - ramp shape: linear, weak, strong, curvilinear
// - S-curve zones 5% or 10% of max
// - set time covers linear part only
// - curvilinear slows above base frequency
// - direction inhibit: none, reverse, forward
// - search enabled separately restart and startup
// - search input on digital input, code 26
// - unassigned search input reads OFF
// - search lasts at most 1.2 seconds
// - after search, ramp to reference
// - search enable table of mode and input
// - run command start waits search delay
`timescale 1ns/1ps
module drs_top import drs_pkg::*; #(
	parameter int TICK_CYCLES = TICK_CYC,
	parameter int FAN_HOLD = FAN_HOLD_TICKS
) (
	// clock and reset
	input wire logic CLOCK,
	input wire logic RSTN,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// run terminals
	input wire logic RUN_FWD,
	input wire logic RUN_REV,
	input wire logic COAST_STOP,
	input wire logic [4:0] DIN,
	input wire logic PF_RESTORE,
	// protection and temperature
	input wire logic TRIP,
	input wire logic [6:0] TRIP_CAUSE,
	input wire logic TEMP_LOW,
	// speed search
	input wire logic SPEED_FOUND,
	input wire logic [15:0] SPEED_EST,
	// outputs
	output logic ALARM,
	output logic [2:0] Y_OUT,
	output logic FAN_ON,
	output logic SEARCH_ACTIVE,
	output logic DRIVE_FWD,
	output logic DRIVE_REV,
	output logic [15:0] FREQ_OUT
);
	logic rst_meta;
	logic rst_n;
	drs_pins_t syn_meta;
	drs_pins_t syn;
	drs_ctrl_t ctrl;
	logic [15:0] rint;
	logic [6:0] sdly;
	logic [17:0] oasg;
	logic [29:0] iasg;
	logic [15:0] fref;
	logic [15:0] maxf;
	logic [15:0] basef;
	logic [15:0] step;
	logic wr;
	logic alm_clr;
	logic hit;
	logic [31:0] rdata;
	logic [31:0] tick_cnt;
	logic tick;
	logic [4:0] stm_hit;
	logic start_search_enable_input;
	logic norm_en;
	logic pf_en;
	logic run_cmd;
	logic run_q;
	logic coast_q;
	logic trip_q;
	logic pf_q;
	logic trip_rise;
	logic run_rise;
	logic coast_fall;
	logic pf_rise;
	logic retry_ok;
	logic [15:0] tmr;
	logic rint_done;
	logic delay_done;
	logic search_done;
	logic [3:0] rcount;
	logic [4:0] rc_next;
	logic dir_rev;
	logic fan_want;
	logic [31:0] fan_hold;
	logic [2:0] y_next;
	drs_state_t state;
	drs_state_t next_state;
	logic tmr_clr;
	logic rc_inc;

	drs_ramp_if rif();
	drs_ramp u_ramp(.clk(CLOCK), .rst_n(rst_n), .rif(rif));

	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!rst_n);

	// reset release through two flops
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// terminals are asynchronous; estimate is read only once found is seen
	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			syn_meta <= '0;
			syn <= '0;
		end else begin
			syn_meta <= {SPEED_EST, SPEED_FOUND, PF_RESTORE, TEMP_LOW,
				TRIP_CAUSE, TRIP, DIN, COAST_STOP, RUN_REV, RUN_FWD};
			syn <= syn_meta;
		end
	end

	// apb register writes
	assign wr = PSEL & PENABLE & PWRITE & PREADY;
	assign alm_clr = wr & (PADDR == A_CMD) & PWDATA[CMD_ALM_CLR];
	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= '0;
			rint <= RINT_RST;
			sdly <= SDLY_RST;
			oasg <= '0;
			iasg <= '0;
			fref <= FREF_RST;
			maxf <= MAXF_RST;
			basef <= BASEF_RST;
			step <= STEP_RST;
		end else if (wr) begin
			unique case (PADDR)
				A_CTRL: ctrl <= drs_ctrl_t'(PWDATA & CTRL_MASK);
				A_RINT: rint <= PWDATA[15:0];
				A_SDLY: sdly <= (PWDATA[6:0] > SDLY_MAX) ? SDLY_MAX :
					PWDATA[6:0];
				A_OASG: oasg <= PWDATA[17:0];
				A_IASG: iasg <= PWDATA[29:0];
				A_FREF: fref <= PWDATA[15:0];
				A_FLIM: {basef, maxf} <= PWDATA;
				A_STEP: step <= PWDATA[15:0];
				default: ;
			endcase
		end
	end

	always_comb begin
		hit = 1'b1;
		unique case (PADDR)
			A_CTRL: rdata = ctrl;
			A_RINT: rdata = {16'h0000, rint};
			A_SDLY: rdata = {25'h0000000, sdly};
			A_OASG: rdata = {14'h0000, oasg};
			A_IASG: rdata = {2'h0, iasg};
			A_CMD: rdata = 32'h0000_0000;
			A_STAT: rdata = {FREQ_OUT, 4'h0, FAN_ON, start_search_enable_input, rcount, state};
			A_FREF: rdata = {16'h0000, fref};
			A_FLIM: rdata = {basef, maxf};
			A_STEP: rdata = {16'h0000, step};
			default: begin
				rdata = 32'h0000_0000;
				hit = 1'b0;
			end
		endcase
	end

	// one wait-free access phase; data captured in setup
	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			PREADY <= 1'b0;
			PRDATA <= 32'h0000_0000;
			PSLVERR <= 1'b0;
		end else begin
			PREADY <= PSEL & ~PENABLE;
			if (PSEL && !PENABLE) begin
				PRDATA <= rdata;
				PSLVERR <= ~hit;
			end
		end
	end

	// millisecond tick
	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt <= 32'h0000_0000;
			tick <= 1'b0;
		end else if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
			tick_cnt <= 32'h0000_0000;
			tick <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 32'h0000_0001;
			tick <= 1'b0;
		end
	end

	// search input: any input terminal carrying the search code
	for (genvar gi = 0; gi < 5; gi++) begin : g_stm
		assign stm_hit[gi] = (iasg[gi*ASG_W +: ASG_W] == FUNC_SEARCH) &
			syn.din[gi];
	end
	assign start_search_enable_input = |stm_hit;
	assign norm_en = start_search_enable_input | (ctrl.smode == SM_BOTH);
	assign pf_en = norm_en | (ctrl.smode == SM_PF);

	// a blocked direction never counts as a run command
	assign run_cmd = (syn.fwd ^ syn.rev) &
		((syn.fwd & (ctrl.dir != DIR_FWD_BLK)) |
		(syn.rev & (ctrl.dir != DIR_REV_BLK)));

	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			run_q <= 1'b0;
			coast_q <= 1'b0;
			trip_q <= 1'b0;
			pf_q <= 1'b0;
		end else begin
			run_q <= run_cmd;
			coast_q <= syn.coast;
			trip_q <= syn.trip;
			pf_q <= syn.pf;
		end
	end
	assign trip_rise = syn.trip & ~trip_q;
	assign run_rise = run_cmd & ~run_q;
	assign coast_fall = ~syn.coast & coast_q;
	assign pf_rise = syn.pf & ~pf_q;
	assign retry_ok = (|syn.cause) & (ctrl.lim != 4'h0) &
		(rcount < ctrl.lim);
	assign rc_next = {1'b0, rcount} + 5'h01;

	assign rint_done = (tmr >= rint);
	assign delay_done = (tmr >= 16'(sdly * SDLY_UNIT_TICKS));
	assign search_done = syn.found |
		(tmr >= 16'(SEARCH_MAX_TICKS));

	always_comb begin
		next_state = state;
		rc_inc = 1'b0;
		unique case (state)
			ST_IDLE: begin
				if (!syn.coast && run_rise) begin
					next_state = norm_en ? ST_DELAY : ST_RUN;
				end else if (run_cmd && coast_fall) begin
					next_state = norm_en ? ST_SEARCH : ST_RUN;
				end else if (!syn.coast && run_cmd && pf_rise && ctrl.pfr) begin
					next_state = pf_en ? ST_SEARCH : ST_RUN;
				end
			end
			ST_DELAY: begin
				if (syn.coast || !run_cmd) begin
					next_state = ST_IDLE;
				end else if (delay_done) begin
					next_state = ST_SEARCH;
				end
			end
			ST_SEARCH: begin
				if (syn.coast || !run_cmd) begin
					next_state = ST_IDLE;
				end else if (search_done) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (syn.coast || (!run_cmd && rif.freq == 16'h0000)) begin
					next_state = ST_IDLE;
				end
			end
			ST_TRIP: begin
				if (rint_done) begin
					rc_inc = 1'b1;
					if (syn.trip) begin
						next_state = (rc_next < {1'b0, ctrl.lim}) ? ST_TRIP :
							ST_ALARM;
					end else if (run_cmd && !syn.coast) begin
						next_state = norm_en ? ST_SEARCH : ST_RUN;
					end else begin
						next_state = ST_IDLE;
					end
				end
			end
			ST_ALARM: begin
				if (alm_clr && !syn.trip) begin
					next_state = ST_IDLE;
				end
			end
		endcase
		if (trip_rise && state != ST_TRIP && state != ST_ALARM) begin
			next_state = retry_ok ? ST_TRIP : ST_ALARM;
		end
		tmr_clr = (next_state != state) | rc_inc;
	end

	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// one tick timer, restarted at every state change and retry
	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			tmr <= 16'h0000;
		end else if (tmr_clr) begin
			tmr <= 16'h0000;
		end else if (tick && tmr != 16'hffff) begin
			tmr <= tmr + 16'h0001;
		end
	end

	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			rcount <= 4'h0;
		end else if (state == ST_ALARM && next_state == ST_IDLE) begin
			rcount <= 4'h0;
		end else if (rc_inc && rcount != 4'hf) begin
			rcount <= rc_next[3:0];
		end else if (state == ST_RUN && rif.at_target && run_cmd) begin
			rcount <= 4'h0;
		end
	end

	// ramp commands; output is cut to zero on any exit from running
	assign rif.tick = tick;
	assign rif.maxf = maxf;
	assign rif.basef = basef;
	assign rif.step = step;
	assign rif.shape = ctrl.shape;
	assign rif.target = (state == ST_RUN && run_cmd) ?
		((fref > maxf) ? maxf : fref) : 16'h0000;
	assign rif.load = (next_state == ST_RUN) != (state == ST_RUN);
	// an estimate above maximum falls back to a normal start
	assign rif.load_val = (state == ST_SEARCH && syn.found &&
		syn.est <= maxf) ? syn.est : 16'h0000;

	// fan: hold time restarts at each switch-on
	assign fan_want = ~ctrl.fan | ~syn.temp_low | (state == ST_RUN) |
		(state == ST_SEARCH);
	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			FAN_ON <= 1'b0;
			fan_hold <= 32'h0000_0000;
		end else if (fan_want && !FAN_ON) begin
			FAN_ON <= 1'b1;
			fan_hold <= 32'(FAN_HOLD);
		end else begin
			FAN_ON <= fan_want | (fan_hold != 32'h0000_0000);
			if (tick && fan_hold != 32'h0000_0000) begin
				fan_hold <= fan_hold - 32'h0000_0001;
			end
		end
	end

	for (genvar gi = 0; gi < 3; gi++) begin : g_yout
		assign y_next[gi] = (oasg[gi*ASG_W +: ASG_W] == FUNC_RETRY) &
			((state == ST_TRIP) | (rcount != 4'h0));
	end

	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			dir_rev <= 1'b0;
			ALARM <= 1'b0;
			Y_OUT <= 3'h0;
			SEARCH_ACTIVE <= 1'b0;
			DRIVE_FWD <= 1'b0;
			DRIVE_REV <= 1'b0;
			FREQ_OUT <= 16'h0000;
		end else begin
			if (state == ST_IDLE) begin
				dir_rev <= syn.rev;
			end
			ALARM <= (state == ST_ALARM);
			Y_OUT <= y_next;
			SEARCH_ACTIVE <= (state == ST_SEARCH);
			DRIVE_FWD <= (state == ST_RUN || state == ST_SEARCH) & ~dir_rev;
			DRIVE_REV <= (state == ST_RUN || state == ST_SEARCH) & dir_rev;
			FREQ_OUT <= rif.freq;
		end
	end

	retry_noalm_a: assert property ((state == ST_TRIP) |=> !ALARM)
		else $error("alarm raised while retrying");
	alarm_limit_a: assert property ((state == ST_TRIP && rint_done &&
		syn.trip && rc_next >= {1'b0, ctrl.lim}) |=> state == ST_ALARM)
		else $error("retry limit passed without alarm");
	cause_gate_a: assert property ((trip_rise && syn.cause == 7'h00 &&
		state != ST_TRIP && state != ST_ALARM) |=> state == ST_ALARM)
		else $error("ineligible trip retried");
	zero_limit_a: assert property ((trip_rise && ctrl.lim == 4'h0 &&
		state != ST_TRIP && state != ST_ALARM) |=> ##1 ALARM)
		else $error("retry with zero limit");
	retry_wait_a: assert property ((state == ST_TRIP && !rint_done) |=>
		(state == ST_TRIP && rcount == $past(rcount)))
		else $error("reset issued before interval");
	retry_out_a: assert property ((oasg[5:0] == FUNC_RETRY &&
		state == ST_TRIP) |=> Y_OUT[0])
		else $error("retry flag not shown");
	fan_always_a: assert property ((!ctrl.fan) |=> FAN_ON)
		else $error("fan off in continuous mode");
	fan_hold_a: assert property ($fell(FAN_ON) |->
		$past(fan_hold) == 32'h0000_0000)
		else $error("fan stopped inside hold time");
	dir_block_a: assert property ((state == ST_IDLE && !syn.fwd &&
		ctrl.dir == DIR_REV_BLK && $stable(ctrl.dir)) |=>
		state != ST_DELAY && state != ST_RUN)
		else $error("inhibited direction started");
	search_len_a: assert property ((state == ST_SEARCH) |->
		tmr <= 16'(SEARCH_MAX_TICKS))
		else $error("search too long");
	stm_off_a: assert property ((state == ST_IDLE && run_rise &&
		!syn.coast && !trip_rise && ctrl.smode == SM_OFF && !start_search_enable_input) |=>
		state == ST_RUN)
		else $error("search without enable");
	count_clear_a: assert property ((state == ST_RUN && rif.at_target &&
		run_cmd && next_state == ST_RUN) |=> rcount == 4'h0)
		else $error("retry count kept after recovery");

	retry_run_c: cover property (state == ST_TRIP ##1 state == ST_SEARCH);
	alarm_c: cover property ($rose(state == ST_ALARM));
	found_c: cover property (state == ST_SEARCH && syn.found);
	fan_off_c: cover property ($fell(FAN_ON));
endmodule

// File: verif/drs_motor.sv
/*
 drs_motor: idling motor seen by the speed search of the drive.
 Assumes the drive holds SEARCH_ACTIVE high while it searches.
*/
`timescale 1ns/1ps
module drs_motor (
	// clock
	input wire logic clk,
	// drive side
	input wire logic search,
	// bench side: lag of ffff never answers
	input wire logic [15:0] lag,
	input wire logic [15:0] speed,
	// feedback
	output logic found,
	output logic [15:0] est
);
	int n;
	always @(posedge clk) begin
		n <= search ? n + 1 : 0;
	end
	assign found = search && lag != 16'hffff && n >= 32'(lag);
	// no stale estimate outside a found window
	assign est = found ? speed : ~speed;
endmodule

// File: verif/test_drive_restart_start_control.sv
/*
 test_drive_restart_start_control: self-checking bench for drs_top.
 Assumes short tick and fan hold parameters for simulation.
*/
`timescale 1ns/1ps
module test_drive_restart_start_control;
	import drs_pkg::*;
	typedef struct packed {
		logic [7:0] a;
		logic [31:0] r;
		logic [31:0] w;
		logic [31:0] e;
	} drs_row_t;
	logic CLOCK, RSTN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, slv;
	logic RUN_FWD, RUN_REV, COAST_STOP, PF_RESTORE, TRIP, TEMP_LOW;
	logic SPEED_FOUND, ALARM, FAN_ON, SEARCH_ACTIVE, DRIVE_FWD, DRIVE_REV;
	logic [7:0] PADDR;
	logic [31:0] PWDATA, PRDATA, rd;
	logic [4:0] DIN;
	logic [6:0] TRIP_CAUSE;
	logic [15:0] SPEED_EST, FREQ_OUT, lag;
	logic [2:0] Y_OUT;
	int n_errors = 0;
	int comparisons = 0;
	int cycles = 0;
	drs_row_t rows[10] = '{
		'{A_CTRL, 32'h0, 32'h0000_f5a5, 32'h0000_05a5},
		'{A_RINT, 32'h0000_03e8, 32'h1234_0005, 32'h0000_0005},
		'{A_SDLY, 32'h0, 32'h0000_007f, 32'h0000_0064},
		'{A_OASG, 32'h0, 32'hffff_ffff, 32'h0003_ffff},
		'{A_IASG, 32'h0, 32'hffff_ffff, 32'h3fff_ffff},
		'{A_CMD, 32'h0, 32'h0, 32'h0},
		'{A_FREF, 32'h0, 32'hffff_ffff, 32'h0000_ffff},
		'{A_FLIM, 32'h1770_1770, 32'h1770_1770, 32'h1770_1770},
		'{A_STEP, 32'h0000_000a, 32'h0000_000a, 32'h0000_000a},
		'{8'h28, 32'h0, 32'h1, 32'h0}
	};

	drs_top #(.TICK_CYCLES(20), .FAN_HOLD(50)) dut (
		.CLOCK(CLOCK), .RSTN(RSTN), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
		.PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .RUN_FWD(RUN_FWD), .RUN_REV(RUN_REV),
		.COAST_STOP(COAST_STOP), .DIN(DIN),
		.PF_RESTORE(PF_RESTORE), .TRIP(TRIP),
		.TRIP_CAUSE(TRIP_CAUSE), .TEMP_LOW(TEMP_LOW),
		.SPEED_FOUND(SPEED_FOUND), .SPEED_EST(SPEED_EST),
		.ALARM(ALARM), .Y_OUT(Y_OUT), .FAN_ON(FAN_ON),
		.SEARCH_ACTIVE(SEARCH_ACTIVE), .DRIVE_FWD(DRIVE_FWD),
		.DRIVE_REV(DRIVE_REV), .FREQ_OUT(FREQ_OUT));
	drs_motor mot (.clk(CLOCK), .search(SEARCH_ACTIVE), .lag(lag),
		.speed(16'h0032), .found(SPEED_FOUND), .est(SPEED_EST));

	initial begin
		CLOCK = 0;
		forever #25 CLOCK = ~CLOCK;
	end

	task automatic close_out();
		if (n_errors == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// bound on the whole run, search timeout included
	always @(posedge CLOCK) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			n_errors++;
			close_out();
		end
	end

	task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask

	task automatic cyc(int n);
		repeat (n) @(posedge CLOCK);
	endtask

	// one transfer, then an idle cycle so psel never toggles twice at once
	// no wait limit here: only the bench timeout ends a stuck access
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		{PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, w, a, d};
		@(posedge CLOCK);
		PENABLE <= 1;
		do begin
			@(posedge CLOCK);
		end while (PREADY !== 1'b1);
		rd = PRDATA;
		slv = PSLVERR;
		{PSEL, PENABLE} <= 2'h0;
		@(posedge CLOCK);
	endtask

	task automatic wr(logic [7:0] a, logic [31:0] d);
		apb(1, a, d);
	endtask

	task automatic trip(logic [6:0] c, logic lvl, int n);
		{TRIP_CAUSE, TRIP} <= {c, lvl};
		cyc(n);
	endtask

	initial begin
		{PSEL, PENABLE, PWRITE, RUN_FWD, RUN_REV, COAST_STOP} = 6'h0;
		{PF_RESTORE, TRIP, TEMP_LOW, RSTN} = 4'h0;
		{PADDR, PWDATA, DIN, TRIP_CAUSE} = '0;
		lag = 16'h0028;
		cyc(2);
		chk("rst", {ALARM, Y_OUT, SEARCH_ACTIVE, DRIVE_FWD, FREQ_OUT}, 0);
		RSTN <= 1;
		cyc(6);
		foreach (rows[i]) begin
			apb(0, rows[i].a, 0);
			chk("reset", rd, rows[i].r);
			chk("slverr", slv, rows[i].a == 8'h28);
			wr(rows[i].a, rows[i].w);
			apb(0, rows[i].a, 0);
			chk("rw", rd, rows[i].e);
		end
		wr(A_SDLY, 0);
		wr(A_FREF, 32'h14);
		wr(A_RINT, 32'ha);
		wr(A_OASG, 32'h0001_a01a);
		wr(A_IASG, 0);
		// run every direction under every inhibit setting
		for (int d = 0; d < 3; d++)
			for (int r = 0; r < 2; r++) begin
				wr(A_CTRL, 32'(d * 128 + 15));
				{RUN_REV, RUN_FWD} <= r ? 2'h2 : 2'h1;
				cyc(80);
				chk("fwd", DRIVE_FWD, r == 0 && d != 2);
				chk("rev", DRIVE_REV, r == 1 && d != 1);
				chk("nosrch", SEARCH_ACTIVE, 0);
				{RUN_REV, RUN_FWD} <= 2'h0;
				cyc(80);
			end
		wr(A_CTRL, 32'h2);
		RUN_FWD <= 1;
		cyc(80);
		chk("frq", FREQ_OUT, 32'h14);
		trip(7'h01, 1, 10);
		chk("alm", ALARM, 0);
		chk("try", Y_OUT, 3'h5);
		trip(7'h01, 0, 130);
		apb(0, A_STAT, 0);
		chk("wait", rd[5:0], 6'h10);
		cyc(160);
		chk("resume", DRIVE_FWD, 1);
		cyc(80);
		chk("cnt", Y_OUT, 0);
		trip(7'h02, 1, 300);
		chk("alm1", ALARM, 0);
		cyc(180);
		chk("alm2", ALARM, 1);
		wr(A_CMD, 1);
		chk("held", ALARM, 1);
		RUN_FWD <= 0;
		trip(7'h00, 0, 10);
		wr(A_CMD, 1);
		cyc(6);
		chk("clr", ALARM, 0);
		wr(A_CTRL, 32'hf);
		for (int i = 0; i < 8; i++) begin
			trip(7'(i < 7 ? 1 << i : 0), 1, 10);
			chk("cause", ALARM, i == 7);
			trip(7'h00, 0, 260);
		end
		wr(A_CMD, 1);
		wr(A_CTRL, 0);
		trip(7'h04, 1, 10);
		chk("lim0", ALARM, 1);
		trip(7'h00, 0, 10);
		wr(A_CMD, 1);
		chk("fan0", FAN_ON, 1);
		wr(A_CTRL, 32'h10);
		TEMP_LOW <= 1;
		cyc(10);
		chk("fanoff", FAN_ON, 0);
		TEMP_LOW <= 0;
		cyc(10);
		TEMP_LOW <= 1;
		cyc(900);
		chk("fanhold", FAN_ON, 1);
		cyc(200);
		chk("fanend", FAN_ON, 0);
		// mode 1, terminal high but unassigned: plain start
		wr(A_CTRL, 32'h200);
		DIN <= 5'h1f;
		RUN_FWD <= 1;
		cyc(60);
		chk("unasg", SEARCH_ACTIVE, 0);
		RUN_FWD <= 0;
		cyc(80);
		wr(A_IASG, 32'h1a);
		wr(A_SDLY, 1);
		wr(A_FREF, 32'hc8);
		lag <= 16'hffff;
		RUN_FWD <= 1;
		cyc(1800);
		chk("delay", SEARCH_ACTIVE, 0);
		cyc(400);
		chk("srch", SEARCH_ACTIVE, 1);
		cyc(22000);
		chk("srchmax", SEARCH_ACTIVE, 1);
		cyc(2000);
		chk("srchend", SEARCH_ACTIVE, 0);
		RUN_FWD <= 0;
		DIN <= 5'h0;
		lag <= 16'h0028;
		cyc(600);
		wr(A_SDLY, 0);
		wr(A_CTRL, 32'h400);
		RUN_FWD <= 1;
		cyc(30);
		chk("mode2", SEARCH_ACTIVE, 1);
		cyc(100);
		chk("found", SEARCH_ACTIVE, 0);
		chk("est", FREQ_OUT >= 16'h0032, 1);
		cyc(600);
		chk("ref", FREQ_OUT, 32'hc8);
		RUN_FWD <= 0;
		cyc(600);
		// strong rounded and curvilinear ramps run longer than linear
		wr(A_FLIM, 32'h0064_1770);
		for (int s = 2; s < 4; s++) begin
			wr(A_CTRL, 32'(s * 32));
			RUN_FWD <= 1;
			cyc(500);
			chk("shape", FREQ_OUT < 16'h00c8, 1);
			cyc(500);
			chk("shend", FREQ_OUT, 32'hc8);
			RUN_FWD <= 0;
			cyc(900);
		end
		// alarm cleared with run held, then power restore in mode 1
		wr(A_CTRL, 32'ha00);
		RUN_FWD <= 1;
		trip(7'h01, 1, 10);
		trip(7'h00, 0, 10);
		wr(A_CMD, 1);
		PF_RESTORE <= 1;
		cyc(10);
		chk("pfsrch", SEARCH_ACTIVE, 1);
		cyc(100);
		COAST_STOP <= 1;
		cyc(10);
		chk("coast", DRIVE_FWD, 0);
		wr(A_CTRL, 32'h400);
		COAST_STOP <= 0;
		cyc(10);
		chk("bxsrch", SEARCH_ACTIVE, 1);
		close_out();
	end
endmodule
